// ===== rsc_cfg.svh
// rsc_cfg.svh: offsets, field positions, reset values and timing of the reset source control.
// assumes: included by the package and the design file; definitions only.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RSC_OFF_CAUSE 12'h000
`define RSC_OFF_SOFT_RST 12'h004
`define RSC_OFF_CORE_CTRL 12'h008
`define RSC_OFF_ALT_FUNC 12'h00c
`define RSC_OFF_SUPPLY_CTRL 12'h010
`define RSC_OFF_IDENT_0 12'h020
`define RSC_OFF_IDENT_1 12'h024
`define RSC_OFF_CAPS_0 12'h028
`define RSC_OFF_CAPS_4 12'h038

// ************************************************************
// cause bit positions
// ************************************************************
`define RSC_CAUSE_EXT 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_SDD 2
`define RSC_CAUSE_SW 3
`define RSC_CAUSE_WDT 4
`define RSC_CAUSE_REG 5
`define RSC_CAUSE_W 6

// ************************************************************
// control fields
// ************************************************************
`define RSC_SYSREQ_BIT 2
`define RSC_NMI_AF_BIT 0
`define RSC_SDD_EN_BIT 0
`define RSC_REG_EN_BIT 1
`define RSC_ZERO32 32'h0000_0000

// ************************************************************
// timing
// ************************************************************
`define RSC_CLK_MHZ 125
`define RSC_SDD_HOLD_US 500
`define RSC_SDD_HOLD_CYC (`RSC_SDD_HOLD_US * `RSC_CLK_MHZ)
`define RSC_REL_CYC 4

`endif

// ===== rsc_pkg.sv
// rsc_pkg.sv: types of the reset source control.
// assumes: rsc_cfg.svh sits beside it.
`include "rsc_cfg.svh"
package rsc_pkg;
    typedef enum logic [2:0] {
        rsc_st_hold,
        rsc_st_fetch_sp,
        rsc_st_fetch_pc,
        rsc_st_fetch_ins,
        rsc_st_run
    } rsc_boot_type;

    typedef struct packed {
        logic core;
        logic tap_logic;
        logic tap_pins;
        logic periph;
    } rsc_domains_type;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } rsc_apb_req_type;
endpackage

// ===== rsc_top.sv
// rsc_top.sv: reset source collection, domain reset generation, boot fetch sequencing,
// sticky cause record, identification and per-peripheral soft resets over apb.
// assumes: one 125 mhz clock; supply detectors and pin are asynchronous; core acks fetches.
`timescale 1ns/100ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_top #(
    parameter int NUM_PERIPH = 16,
    parameter int SDD_HOLD_CYC = `RSC_SDD_HOLD_CYC,
    parameter logic [31:0] IDENT_0 = 32'h0001_0000, // arbitrary value
    parameter logic [31:0] IDENT_1 = 32'h0002_0000, // arbitrary value
    parameter logic [31:0] CAPS = 32'h0000_00ff // arbitrary value
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ext_rst_n_in,
    input wire logic por_active_in,
    input wire logic supply_drop_in,
    input wire logic watchdog_rst_in,
    input wire logic regulator_loss_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic fetch_ack_in,
    output logic core_rst_n_out,
    output logic tap_rst_n_out,
    output logic tap_pin_rst_n_out,
    output logic [NUM_PERIPH-1:0] periph_rst_n_out,
    output logic fetch_sp_out,
    output logic fetch_pc_out,
    output logic fetch_ins_out,
    output logic core_run_out,
    output logic nmi_func_out
);
    // ************************************************************
    // reset release, synchronisers
    // ************************************************************
    // internal oscillator is modelled as the same clock; no separate domain here
    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] pin_sync, por_sync, sdd_sync, wdt_sync, reg_sync;
    rsc_pkg::rsc_apb_req_type req;
    assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in,
                   pwrite: pwrite_in, pwdata: pwdata_in};

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pin and detectors are asynchronous; three stages, the last two must agree
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 3'h7;
            por_sync <= 3'h7;
            sdd_sync <= 3'h0;
            wdt_sync <= 3'h0;
            reg_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], ext_rst_n_in};
            por_sync <= {por_sync[1:0], por_active_in};
            sdd_sync <= {sdd_sync[1:0], supply_drop_in};
            wdt_sync <= {wdt_sync[1:0], watchdog_rst_in};
            reg_sync <= {reg_sync[1:0], regulator_loss_in};
        end
    end

    // ************************************************************
    // filtered source levels
    // ************************************************************
    logic pin_low, por_on, sdd_on, wdt_on, reg_on;
    logic next_pin_low, next_por_on, next_sdd_on, next_wdt_on, next_reg_on;
    logic por_seen, next_por_seen;
    logic sdd_latched, next_sdd_latched;
    logic [31:0] sdd_cnt, next_sdd_cnt;
    logic [31:0] core_ctrl, soft_rst, alt_func, supply_ctrl;
    logic [`RSC_CAUSE_W-1:0] cause;

    always_comb begin
        next_pin_low = (pin_sync[2] == pin_sync[1]) ? !pin_sync[2] : pin_low;
        next_por_on = (por_sync[2] == por_sync[1]) ? por_sync[2] : por_on;
        next_sdd_on = (sdd_sync[2] == sdd_sync[1]) ? sdd_sync[2] : sdd_on;
        next_wdt_on = (wdt_sync[2] == wdt_sync[1]) ? wdt_sync[2] : wdt_on;
        next_reg_on = (reg_sync[2] == reg_sync[1]) ? reg_sync[2] : reg_on;
        // detector only counts until first release; later pulses ignored
        next_por_seen = por_seen | (por_on & !next_por_on);
        next_sdd_latched = sdd_latched;
        next_sdd_cnt = sdd_cnt;
        if (sdd_latched) begin
            // self-clearing hold stops a second record before software looks
            if (sdd_cnt == 32'(SDD_HOLD_CYC - 1)) begin
                next_sdd_latched = 1'b0;
                next_sdd_cnt = `RSC_ZERO32;
            end else begin
                next_sdd_cnt = sdd_cnt + 32'h1;
            end
        end else if (sdd_on && supply_ctrl[`RSC_SDD_EN_BIT]) begin
            next_sdd_latched = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_low <= 1'b0;
            por_on <= 1'b1;
            sdd_on <= 1'b0;
            wdt_on <= 1'b0;
            reg_on <= 1'b0;
            por_seen <= 1'b0;
            sdd_latched <= 1'b0;
            sdd_cnt <= `RSC_ZERO32;
        end else begin
            pin_low <= next_pin_low;
            por_on <= next_por_on;
            sdd_on <= next_sdd_on;
            wdt_on <= next_wdt_on;
            reg_on <= next_reg_on;
            por_seen <= next_por_seen;
            sdd_latched <= next_sdd_latched;
            sdd_cnt <= next_sdd_cnt;
        end
    end

    // ************************************************************
    // source collection and domain mapping
    // ************************************************************
    logic src_por, src_pin, src_sdd, src_sw, src_wdt, src_reg, sys_rst;
    rsc_pkg::rsc_domains_type dom;
    assign src_por = por_on & !por_seen;
    assign src_pin = pin_low;
    assign src_sdd = sdd_on & supply_ctrl[`RSC_SDD_EN_BIT] & !sdd_latched;
    assign src_sw = core_ctrl[`RSC_SYSREQ_BIT];
    assign src_wdt = wdt_on;
    assign src_reg = reg_on & supply_ctrl[`RSC_REG_EN_BIT];
    assign sys_rst = src_por | src_pin | src_sdd | src_sw | src_wdt | src_reg;

    always_comb begin
        dom.core = sys_rst;
        dom.periph = sys_rst;
        dom.tap_logic = src_por;
        dom.tap_pins = src_por | src_pin;
    end

    // ************************************************************
    // boot sequencer
    // ************************************************************
    rsc_pkg::rsc_boot_type st, next_st;
    logic [3:0] rel_cnt, next_rel_cnt;

    always_comb begin
        next_st = st;
        next_rel_cnt = rel_cnt;
        unique case (st)
            rsc_pkg::rsc_st_hold: begin
                // held while any source is active; the power-on detector counts only until its first release
                if (sys_rst) begin
                    next_rel_cnt = 4'h0;
                end else if (rel_cnt == 4'(`RSC_REL_CYC - 1)) begin
                    next_st = rsc_pkg::rsc_st_fetch_sp;
                end else begin
                    next_rel_cnt = rel_cnt + 4'h1;
                end
            end
            rsc_pkg::rsc_st_fetch_sp: if (fetch_ack_in) next_st = rsc_pkg::rsc_st_fetch_pc;
            rsc_pkg::rsc_st_fetch_pc: if (fetch_ack_in) next_st = rsc_pkg::rsc_st_fetch_ins;
            rsc_pkg::rsc_st_fetch_ins: if (fetch_ack_in) next_st = rsc_pkg::rsc_st_run;
            rsc_pkg::rsc_st_run: next_st = st;
        endcase
        if (sys_rst) begin
            next_st = rsc_pkg::rsc_st_hold;
            next_rel_cnt = 4'h0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= rsc_pkg::rsc_st_hold;
            rel_cnt <= 4'h0;
        end else begin
            st <= next_st;
            rel_cnt <= next_rel_cnt;
        end
    end

    // ************************************************************
    // apb registers
    // ************************************************************
    logic wr, rd_ok;
    logic [`RSC_CAUSE_W-1:0] next_cause, hit;
    logic [31:0] next_core_ctrl, next_soft_rst, next_alt_func, next_supply_ctrl;
    logic [31:0] next_prdata, soft_prev, next_soft_prev, pulse, next_pulse;
    logic in_rst, next_in_rst;

    assign wr = req.psel & req.penable & req.pwrite;
    assign pready_out = 1'b1;
    assign pslverr_out = req.psel & req.penable & !rd_ok;

    always_comb begin
        unique case (req.paddr)
            `RSC_OFF_CAUSE, `RSC_OFF_SOFT_RST, `RSC_OFF_CORE_CTRL, `RSC_OFF_ALT_FUNC,
            `RSC_OFF_SUPPLY_CTRL, `RSC_OFF_IDENT_0, `RSC_OFF_IDENT_1: rd_ok = 1'b1;
            default: rd_ok = (req.paddr >= `RSC_OFF_CAPS_0) && (req.paddr <= `RSC_OFF_CAPS_4)
                             && (req.paddr[1:0] == 2'h0);
        endcase
    end

    always_comb begin
        hit = '0;
        hit[`RSC_CAUSE_POR] = src_por;
        hit[`RSC_CAUSE_EXT] = src_pin;
        hit[`RSC_CAUSE_SDD] = src_sdd;
        hit[`RSC_CAUSE_SW] = src_sw;
        hit[`RSC_CAUSE_WDT] = src_wdt;
        hit[`RSC_CAUSE_REG] = src_reg;
        next_in_rst = sys_rst;
        next_cause = cause;
        // software writes zero to clear a bit
        if (wr && req.paddr == `RSC_OFF_CAUSE) next_cause = cause & req.pwdata[`RSC_CAUSE_W-1:0];
        if (src_por) begin
            next_cause = hit; // power-on wipes older causes
        end else if (src_pin) begin
            next_cause = hit;
        end else begin
            next_cause = next_cause | hit; // set wins over clear, sticky
        end
        next_core_ctrl = core_ctrl;
        next_soft_rst = soft_rst;
        next_alt_func = alt_func;
        next_supply_ctrl = supply_ctrl;
        if (wr) begin
            unique case (req.paddr)
                `RSC_OFF_SOFT_RST: next_soft_rst = req.pwdata;
                `RSC_OFF_CORE_CTRL: next_core_ctrl = req.pwdata;
                `RSC_OFF_ALT_FUNC: next_alt_func = req.pwdata;
                `RSC_OFF_SUPPLY_CTRL: next_supply_ctrl = req.pwdata;
                default: next_core_ctrl = core_ctrl; // ident and caps ignore writes
            endcase
        end
        if (in_rst) begin
            // system reset returns core control, soft resets and alt function to defaults, supply control kept; nmi pin back to gpio
            next_core_ctrl = `RSC_ZERO32;
            next_soft_rst = `RSC_ZERO32;
            next_alt_func = `RSC_ZERO32;
        end
        next_soft_prev = soft_rst;
        // one-then-zero edge triggers a one-cycle peripheral reset
        next_pulse = soft_prev & ~soft_rst;
        next_prdata = `RSC_ZERO32;
        unique case (req.paddr)
            `RSC_OFF_CAUSE: next_prdata[`RSC_CAUSE_W-1:0] = cause;
            `RSC_OFF_SOFT_RST: next_prdata = soft_rst;
            `RSC_OFF_CORE_CTRL: next_prdata = core_ctrl;
            `RSC_OFF_ALT_FUNC: next_prdata = alt_func;
            `RSC_OFF_SUPPLY_CTRL: next_prdata = supply_ctrl;
            `RSC_OFF_IDENT_0: next_prdata = IDENT_0;
            `RSC_OFF_IDENT_1: next_prdata = IDENT_1;
            default: next_prdata = rd_ok ? CAPS : `RSC_ZERO32;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cause <= '0;
            core_ctrl <= `RSC_ZERO32;
            soft_rst <= `RSC_ZERO32;
            alt_func <= `RSC_ZERO32;
            supply_ctrl <= `RSC_ZERO32;
            soft_prev <= `RSC_ZERO32;
            pulse <= `RSC_ZERO32;
            in_rst <= 1'b1;
        end else begin
            cause <= next_cause;
            core_ctrl <= next_core_ctrl;
            soft_rst <= next_soft_rst;
            alt_func <= next_alt_func;
            supply_ctrl <= next_supply_ctrl;
            soft_prev <= next_soft_prev;
            pulse <= next_pulse;
            in_rst <= next_in_rst;
        end
    end

    // read data only updates in setup so it is stable through the access phase
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out <= `RSC_ZERO32;
        end else if (req.psel && !req.penable) begin
            prdata_out <= next_prdata;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic core_hold;
    assign core_hold = dom.core | (st == rsc_pkg::rsc_st_hold);
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_n_out <= 1'b0;
            tap_rst_n_out <= 1'b0;
            tap_pin_rst_n_out <= 1'b0;
            fetch_sp_out <= 1'b0;
            fetch_pc_out <= 1'b0;
            fetch_ins_out <= 1'b0;
            core_run_out <= 1'b0;
            nmi_func_out <= 1'b0;
        end else begin
            core_rst_n_out <= !core_hold;
            tap_rst_n_out <= !dom.tap_logic;
            tap_pin_rst_n_out <= !dom.tap_pins;
            fetch_sp_out <= next_st == rsc_pkg::rsc_st_fetch_sp;
            fetch_pc_out <= next_st == rsc_pkg::rsc_st_fetch_pc;
            fetch_ins_out <= next_st == rsc_pkg::rsc_st_fetch_ins;
            core_run_out <= next_st == rsc_pkg::rsc_st_run;
            nmi_func_out <= alt_func[`RSC_NMI_AF_BIT];
        end
    end

    // per-peripheral reset: system reset, held with the core until boot, or own soft pulse
    // a one-cycle source (supply drop) would otherwise release peripherals before the core
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
            always_ff @(posedge clock_in or negedge rst_n) begin
                if (!rst_n) begin
                    periph_rst_n_out[gi] <= 1'b0;
                end else begin
                    periph_rst_n_out[gi] <= !(dom.periph | (st == rsc_pkg::rsc_st_hold) | pulse[gi]);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== rsc_monitor.sv
// rsc_monitor.sv: port assertions for the reset source control.
// assumes: bound to rsc_top; one clock domain, reset arst_n_in.
`timescale 1ns/100ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_monitor #(
    parameter int NUM_PERIPH = 16,
    parameter logic [31:0] IDENT_0 = 32'h0000_0000
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ext_rst_n_in,
    input wire logic por_active_in,
    input wire logic watchdog_rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic core_rst_n_out,
    input wire logic tap_rst_n_out,
    input wire logic tap_pin_rst_n_out,
    input wire logic [NUM_PERIPH-1:0] periph_rst_n_out,
    input wire logic fetch_sp_out,
    input wire logic fetch_pc_out,
    input wire logic fetch_ins_out,
    input wire logic core_run_out,
    input wire logic nmi_func_out
);
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    AST_TAP_POR_ONLY: assert property (!tap_rst_n_out |-> !tap_pin_rst_n_out && !core_rst_n_out)
        else $error("test logic reset without core reset");
    AST_TAP_KEEPS: assert property (tap_rst_n_out |=> tap_rst_n_out)
        else $error("test logic reset again after power-up");
    AST_POR_HOLD: assert property (por_active_in && !tap_rst_n_out |=> !core_rst_n_out && !fetch_sp_out)
        else $error("core left reset while power-on active");
    AST_PIN_DOMAINS: assert property (!ext_rst_n_in [*6] |-> !core_rst_n_out && !tap_pin_rst_n_out && periph_rst_n_out == '0)
        else $error("pin reset domains wrong");
    AST_WDT_CORE: assert property (core_run_out && watchdog_rst_in |-> ##[1:6] (!core_rst_n_out && tap_pin_rst_n_out && periph_rst_n_out == '0))
        else $error("watchdog reset domains wrong");
    AST_SOFT_PULSE: assert property (core_rst_n_out && $past(core_rst_n_out) && $fell(periph_rst_n_out[3]) |=> periph_rst_n_out[3] && core_rst_n_out)
        else $error("soft peripheral reset pulse wrong");
    AST_FETCH_PC: assert property ($rose(fetch_pc_out) |-> $past(fetch_sp_out) && !fetch_sp_out)
        else $error("counter fetch out of order");
    AST_FETCH_INS: assert property ($rose(fetch_ins_out) |-> $past(fetch_pc_out) && !fetch_pc_out)
        else $error("instruction fetch out of order");
    AST_RUN_AFTER: assert property ($rose(core_run_out) |-> $past(fetch_ins_out) && !fetch_ins_out)
        else $error("run before fetches done");
    AST_NMI_CLEAR: assert property (!core_rst_n_out [*3] |-> !nmi_func_out)
        else $error("interrupt pin function kept through reset");
    AST_IDENT_READ: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == `RSC_OFF_IDENT_0 |=> prdata_out == IDENT_0)
        else $error("ident read wrong");
endmodule
bind rsc_top rsc_monitor #(.NUM_PERIPH(NUM_PERIPH), .IDENT_0(IDENT_0)) rsc_monitor_i (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .ext_rst_n_in(ext_rst_n_in),
    .por_active_in(por_active_in), .watchdog_rst_in(watchdog_rst_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .prdata_out(prdata_out), .core_rst_n_out(core_rst_n_out), .tap_rst_n_out(tap_rst_n_out),
    .tap_pin_rst_n_out(tap_pin_rst_n_out), .periph_rst_n_out(periph_rst_n_out),
    .fetch_sp_out(fetch_sp_out), .fetch_pc_out(fetch_pc_out), .fetch_ins_out(fetch_ins_out),
    .core_run_out(core_run_out), .nmi_func_out(nmi_func_out));
`default_nettype wire

// ===== rsc_board.sv
// rsc_board.sv: board pin, supply detectors, watchdog and a core that acks boot fetches.
// assumes: testbench calls set_src; fetches are acked after slow_in idle cycles.
`timescale 1ns/100ps
`default_nettype none
module rsc_board (
    input wire logic clock_in,
    input wire logic [3:0] slow_in,
    input wire logic [2:0] fetch_in,
    output logic [4:0] src_out, // pin, power-on, supply drop, watchdog, regulator; high = active
    output logic fetch_ack_out
);
    // ************************************************************
    // sources and fetch answers
    // ************************************************************
    logic [3:0] cnt;
    initial begin
        src_out = 5'h02; // power-on detector active from the start only
        fetch_ack_out = 1'b0;
        cnt = 4'h0;
    end
    // pin held by caller for the minimum pulse before release
    task automatic set_src(input int idx, input logic val);
        @(posedge clock_in);
        src_out[idx] <= val;
    endtask
    // one-cycle ack so a held level never skips a fetch
    always @(posedge clock_in) begin
        if (fetch_in == 3'h0 || fetch_ack_out) begin
            cnt <= 4'h0;
            fetch_ack_out <= 1'b0;
        end else if (cnt >= slow_in) begin
            fetch_ack_out <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== rsc_tb.sv
// rsc_tb.sv: self-checking testbench for rsc_top over apb.
// assumes: rsc_board models the far side; sources asserted through it.
`timescale 1ns/100ps
`default_nettype none
`include "rsc_cfg.svh"
module testbench;
    localparam logic [31:0] ID0 = 32'h00a5_0001; // arbitrary value
    localparam logic [31:0] ID1 = 32'h005a_0002; // arbitrary value
    localparam logic [31:0] CAPS = 32'h0000_0f3c; // arbitrary value
    localparam int MIN_PULSE = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] slow = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ack, core_rst_n, tap_rst_n, tap_pin_rst_n, fsp, fpc, fins, run, nmi;
    logic [15:0] periph;
    logic [4:0] src;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    // ************************************************************
    // instances
    // ************************************************************
    rsc_top #(.SDD_HOLD_CYC(60), .IDENT_0(ID0), .IDENT_1(ID1), .CAPS(CAPS)) rsc_top_i (
        .clock_in(clk), .arst_n_in(arst_n), .ext_rst_n_in(~src[0]), .por_active_in(src[1]),
        .supply_drop_in(src[2]), .watchdog_rst_in(src[3]), .regulator_loss_in(src[4]),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .fetch_ack_in(ack), .core_rst_n_out(core_rst_n), .tap_rst_n_out(tap_rst_n),
        .tap_pin_rst_n_out(tap_pin_rst_n), .periph_rst_n_out(periph), .fetch_sp_out(fsp),
        .fetch_pc_out(fpc), .fetch_ins_out(fins), .core_run_out(run), .nmi_func_out(nmi));
    rsc_board rsc_board_i (.clock_in(clk), .slow_in(slow), .fetch_in({fsp, fpc, fins}),
        .src_out(src), .fetch_ack_out(ack));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask
    // waits for run to reach a level; a stuck boot ends the run
    task automatic wait_run(input logic val);
        int n;
        n = 0;
        while (run !== val && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (run !== val) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic src_reset(input int idx, input int n, input logic [3:0] dom,
                             input logic [31:0] cause);
        rsc_board_i.set_src(idx, 1'b1);
        repeat (n) @(negedge clk);
        check({28'h0, core_rst_n, tap_rst_n, tap_pin_rst_n, periph == 16'h0}, {28'h0, dom});
        rsc_board_i.set_src(idx, 1'b0);
        wait_run(1'b1);
        rd_chk(`RSC_OFF_CAUSE, cause);
    endtask
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        logic [31:0] v;
        logic [15:0] lowm;
        logic e;
        int n;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge clk);
        rsc_board_i.set_src(1, 1'b0);
        wait_run(1'b1);
        check({28'h0, core_rst_n, tap_rst_n, tap_pin_rst_n, periph == 16'hffff}, 32'hf);
        rd_chk(`RSC_OFF_CAUSE, 32'h2);
        rd_chk(`RSC_OFF_IDENT_0, ID0);
        wr(`RSC_OFF_IDENT_0, 32'hffff_ffff);
        rd_chk(`RSC_OFF_IDENT_0, ID0);
        rd_chk(`RSC_OFF_CAPS_0, CAPS);
        wr(`RSC_OFF_IDENT_1, 32'h0);
        rd_chk(`RSC_OFF_IDENT_1, ID1);
        apb(1'b0, 12'h0f0, 32'h0, v, e);
        check({e, v[30:0]}, 32'h8000_0000);
        check({31'h0, nmi}, 32'h0);
        wr(`RSC_OFF_ALT_FUNC, 32'h1);
        // select bit lands at the access edge, the pin function one edge later
        repeat (2) @(negedge clk);
        check({31'h0, nmi}, 32'h1);
        wr(`RSC_OFF_SOFT_RST, 32'h0000_0008);
        wr(`RSC_OFF_SOFT_RST, 32'h0);
        lowm = 16'h0;
        n = 0;
        repeat (6) begin
            @(negedge clk);
            lowm |= ~periph;
            n += int'(periph != 16'hffff);
        end
        check({lowm, 14'h0, core_rst_n, n == 1}, 32'h0008_0003);
        slow <= 4'h5;
        src_reset(3, 8, 4'b0111, 32'h12);
        check({31'h0, nmi}, 32'h0);
        wr(`RSC_OFF_CORE_CTRL, 32'h4);
        wait_run(1'b0);
        wait_run(1'b1);
        rd_chk(`RSC_OFF_CAUSE, 32'h1a);
        slow <= 4'h0;
        wr(`RSC_OFF_SUPPLY_CTRL, 32'h3);
        src_reset(2, 8, 4'b0111, 32'h1e);
        rsc_board_i.set_src(2, 1'b1);
        repeat (8) @(negedge clk);
        check({30'h0, run, core_rst_n}, 32'h3);
        rsc_board_i.set_src(2, 1'b0);
        src_reset(4, 8, 4'b0111, 32'h3e);
        wr(`RSC_OFF_CAUSE, 32'h3c);
        rd_chk(`RSC_OFF_CAUSE, 32'h3c);
        src_reset(0, MIN_PULSE, 4'b0101, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
